/* logic/branch_timing_defines.svh */
// constants for branch decode and machine cycle timing
`ifndef BRANCH_TIMING_DEFINES_SVH
`define BRANCH_TIMING_DEFINES_SVH

// machine cycle shape
`define STATES_PER_MCYCLE  4
`define CLK_PERIOD_NS      100
`define MCYCLE_CLKS        (`STATES_PER_MCYCLE)

// program counter after reset
`define RESET_PC           16'h0000

// branch and compare opcodes
`define OPC_ACC_NONZERO    8'h70
`define OPC_CARRY_SET      8'h40
`define OPC_CARRY_CLEAR    8'h50
`define OPC_BIT_SET        8'h20
`define OPC_BIT_CLEAR      8'h30
`define OPC_BIT_SET_CLR    8'h10
`define OPC_CMP_ACC_DIRECT 8'hb5
`define OPC_CMP_ACC_IMM    8'hb4
`define OPC_CMP_IND_R0     8'hb6
`define OPC_CMP_IND_R1     8'hb7
`define OPC_CMP_REG_BASE   8'hb8
`define OPC_DEC_REG_BASE   8'hd8
`define OPC_DEC_DIRECT     8'hd5

// lengths and machine cycle counts
`define SHORT_BR_BYTES     2'd2
`define SHORT_BR_CYCLES    3'd3
`define LONG_BR_BYTES      2'd3
`define LONG_BR_CYCLES     3'd4
`define EXT_MOVE_BYTES     2'd1
`define EXT_MOVE_CYCLES    3'd2

`endif

/* logic/branch_timing_pkg.sv */
// types shared by the sequencer and the branch decoder
package branch_timing_pkg;

  // the four states of one machine cycle
  typedef enum logic [1:0] {
    STATE_ONE,
    STATE_TWO,
    STATE_THREE,
    STATE_FOUR
  } mstate_t;

  // instruction classes handled here; all else is other
  typedef enum logic [3:0] {
    CLS_OTHER,
    CLS_ACC_NZ,
    CLS_CARRY_SET,
    CLS_CARRY_CLR,
    CLS_BIT_SET,
    CLS_BIT_CLR,
    CLS_BIT_SET_CLR,
    CLS_CMP_ACC_DIR,
    CLS_CMP_ACC_IMM,
    CLS_CMP_IND,
    CLS_CMP_REG,
    CLS_DEC_REG,
    CLS_DEC_DIR
  } instr_class_t;

  // decode result of one opcode
  typedef struct packed {
    instr_class_t cls;
    logic [1:0]   bytes;
    logic [2:0]   cycles;
  } decode_t;

  // operand values the core presents during execution
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] direct_val;
    logic [7:0] indirect_val;
    logic [7:0] reg_val;
    logic       carry;
    logic       bit_val;
  } operands_t;

  // effects of a completed branch instruction
  typedef struct packed {
    logic       taken;
    logic       carry_we;
    logic       carry_val;
    logic       bit_clear;
    logic       dec_reg_we;
    logic       dec_direct_we;
    logic [7:0] dec_val;
  } exec_result_t;

endpackage

/* logic/mcycle_sequencer.sv */
// four-state machine cycle sequencer
`timescale 1ns/100ps
`include "branch_timing_defines.svh"

module mcycle_sequencer
  import branch_timing_pkg::*;
#(
  parameter int NUM_STATES = `STATES_PER_MCYCLE
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // current state of the machine cycle
  output mstate_t   state_q
);

  // the enum holds exactly four states; refuse any other count when elaborating
  if (NUM_STATES != 4) begin : g_bad_states
    $error("mcycle_sequencer serves exactly four states");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= STATE_ONE;
    end else begin
      case (state_q)
        STATE_ONE:   state_q <= STATE_TWO;
        STATE_TWO:   state_q <= STATE_THREE;
        STATE_THREE: state_q <= STATE_FOUR;
        STATE_FOUR:  state_q <= STATE_ONE;
        default:     state_q <= STATE_ONE;
      endcase
    end
  end

endmodule

/* logic/branch_decode_cycle_timing.sv */
// fetch pacing, decode and execution of branch and compare-jump instructions
`timescale 1ns/100ps
`include "branch_timing_defines.svh"

// Notes on behaviour
// - machine cycle is four clock states
// - states run one, two, three, four, wrap
// - timing uses both clock edges
// - at most one fetch per machine cycle
// - cycles equal bytes for most instructions
// - all 256 opcodes decode; single-cycle only outside the group
// - external data move: one byte, two cycles
// - compare acc direct B5, 3 bytes, 4 cycles
// - compare acc immediate B4, 3 bytes, 4 cycles
// - compare indirect B6/B7, 3 bytes, 4 cycles
// - compare register B8-BF, 3 bytes, 4 cycles
// - decrement direct D5, 3 bytes, 4 cycles
module branch_decode_cycle_timing
  import branch_timing_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // program memory fetch port
  output logic           fetch_en_q,
  output logic [15:0]    fetch_addr_q,
  input  wire logic [7:0] fetch_data,
  // length of opcodes outside this group, from the other decoders
  input  wire logic [1:0] other_bytes,
  input  wire logic      ext_move,
  // operand values from the core
  input  wire operands_t ops,
  // decode state toward the core
  output mstate_t        mstate_q,
  output logic [7:0]     opcode_q,
  output logic [7:0]     operand_addr_q,
  output logic [15:0]    pc_q,
  // completion and effects
  output logic           done_q,
  output exec_result_t   result_q
);

  // cycle index within the instruction
  logic [2:0]   cyc_idx_q;
  // a fetch belongs to the current machine cycle
  logic         fetch_this_q;
  // byte captured on the falling edge
  logic [7:0]   capt_q;
  // third instruction byte
  logic [7:0]   byte2_q;
  // decode and execution terms
  logic [7:0]   cur_op;
  decode_t      dec;
  logic         last;
  logic         need_fetch;
  logic [7:0]   rel;
  logic [15:0]  target;
  logic [15:0]  next_pc;
  logic [7:0]   cmp_a;
  logic [7:0]   cmp_b;
  logic [7:0]   dec_src;
  exec_result_t res;

  // four states make one machine cycle
  mcycle_sequencer #(
    .NUM_STATES (`STATES_PER_MCYCLE)
  ) u_seq (
    .clk     (clk),
    .rst_n   (rst_n),
    .state_q (mstate_q)
  );

  // opcode to class, length and cycle count
  function automatic decode_t decode_op(input logic [7:0] op,
                                        input logic [1:0] obytes,
                                        input logic       xmove);
    decode_t d;
    d.cls    = CLS_OTHER;
    d.bytes  = `SHORT_BR_BYTES;
    d.cycles = `SHORT_BR_CYCLES;
    if (op == `OPC_ACC_NONZERO) begin
      d.cls = CLS_ACC_NZ;
    end else if (op == `OPC_CARRY_SET) begin
      d.cls = CLS_CARRY_SET;
    end else if (op == `OPC_CARRY_CLEAR) begin
      d.cls = CLS_CARRY_CLR;
    end else if ((op & 8'hf8) == `OPC_DEC_REG_BASE) begin
      d.cls = CLS_DEC_REG;
    end else begin
      d.bytes  = `LONG_BR_BYTES;
      d.cycles = `LONG_BR_CYCLES;
      if (op == `OPC_BIT_SET) begin
        d.cls = CLS_BIT_SET;
      end else if (op == `OPC_BIT_CLEAR) begin
        d.cls = CLS_BIT_CLR;
      end else if (op == `OPC_BIT_SET_CLR) begin
        d.cls = CLS_BIT_SET_CLR;
      end else if (op == `OPC_CMP_ACC_DIRECT) begin
        d.cls = CLS_CMP_ACC_DIR;
      end else if (op == `OPC_CMP_ACC_IMM) begin
        d.cls = CLS_CMP_ACC_IMM;
      // compare indirect through r0 or r1
      end else if (op == `OPC_CMP_IND_R0 || op == `OPC_CMP_IND_R1) begin
        d.cls = CLS_CMP_IND;
      end else if ((op & 8'hf8) == `OPC_CMP_REG_BASE) begin
        d.cls = CLS_CMP_REG;
      end else if (op == `OPC_DEC_DIRECT) begin
        d.cls = CLS_DEC_DIR;
      // external move is one byte, two cycles
      end else if (xmove) begin
        d.bytes  = `EXT_MOVE_BYTES;
        d.cycles = `EXT_MOVE_CYCLES;
      // cycles follow bytes; any opcode accepted
      end else begin
        d.bytes  = (obytes == 2'd0) ? 2'd1 : obytes;
        d.cycles = {1'b0, d.bytes};
      end
    end
    return d;
  endfunction

  // decode the fresh opcode in cycle zero, the held one later
  always_comb begin
    cur_op = (cyc_idx_q == 3'd0) ? capt_q : opcode_q;
    dec    = decode_op(cur_op, other_bytes, ext_move);
    last   = (cyc_idx_q == (dec.cycles - 3'd1));
    // one fetch per cycle until all bytes are in
    need_fetch = last || ((cyc_idx_q + 3'd1) < {1'b0, dec.bytes});
  end

  // branch conditions and side effects
  always_comb begin
    res     = '0;
    rel     = (dec.bytes == 2'd3) ? byte2_q : operand_addr_q;
    // offset added to the following address
    target  = pc_q + {{8{rel[7]}}, rel};
    cmp_a   = ops.acc;
    cmp_b   = operand_addr_q;
    dec_src = (dec.cls == CLS_DEC_DIR) ? ops.direct_val : ops.reg_val;
    if (dec.cls == CLS_CMP_ACC_DIR) begin
      cmp_b = ops.direct_val;
    end else if (dec.cls == CLS_CMP_IND) begin
      cmp_a = ops.indirect_val;
    end else if (dec.cls == CLS_CMP_REG) begin
      cmp_a = ops.reg_val;
    end
    case (dec.cls)
      CLS_ACC_NZ:      res.taken = (ops.acc != 8'h00);
      CLS_CARRY_SET:   res.taken = ops.carry;
      CLS_CARRY_CLR:   res.taken = !ops.carry;
      CLS_BIT_SET:     res.taken = ops.bit_val;
      CLS_BIT_CLR:     res.taken = !ops.bit_val;
      // set bit is cleared when jumping
      CLS_BIT_SET_CLR: begin
        res.taken     = ops.bit_val;
        res.bit_clear = ops.bit_val;
      end
      // carry when first operand is below second
      CLS_CMP_ACC_DIR, CLS_CMP_ACC_IMM, CLS_CMP_IND, CLS_CMP_REG: begin
        res.taken     = (cmp_a != cmp_b);
        res.carry_we  = 1'b1;
        res.carry_val = (cmp_a < cmp_b);
      end
      CLS_DEC_REG, CLS_DEC_DIR: begin
        res.dec_val       = dec_src - 8'h01;
        res.taken         = (res.dec_val != 8'h00);
        res.dec_reg_we    = (dec.cls == CLS_DEC_REG);
        res.dec_direct_we = (dec.cls == CLS_DEC_DIR);
      end
      default:         res = '0;
    endcase
    next_pc = res.taken ? target : pc_q;
  end

  // fetched byte sampled on the falling edge in state three
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capt_q <= 8'h00;
    end else if (mstate_q == STATE_THREE && fetch_this_q) begin
      capt_q <= fetch_data;
    end
  end

  // fetch strobe lasts state one of a fetching cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_en_q   <= 1'b1;
      fetch_this_q <= 1'b1;
      fetch_addr_q <= `RESET_PC;
      pc_q         <= `RESET_PC + 16'h0001;
    end else if (mstate_q == STATE_FOUR) begin
      fetch_en_q   <= need_fetch;
      fetch_this_q <= need_fetch;
      // a taken branch redirects the next opcode fetch
      if (need_fetch) begin
        fetch_addr_q <= last ? next_pc : pc_q;
        pc_q         <= (last ? next_pc : pc_q) + 16'h0001;
      end else if (last) begin
        pc_q <= next_pc;
      end
    end else if (mstate_q == STATE_ONE) begin
      fetch_en_q <= 1'b0;
    end
  end

  // cycle index steps once per machine cycle, restarts at last
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_idx_q <= 3'd0;
    end else if (mstate_q == STATE_FOUR) begin
      cyc_idx_q <= last ? 3'd0 : cyc_idx_q + 3'd1;
    end
  end

  // instruction bytes stored at the end of their fetch cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_q       <= 8'h00;
      operand_addr_q <= 8'h00;
      byte2_q        <= 8'h00;
    end else if (mstate_q == STATE_FOUR && fetch_this_q) begin
      case (cyc_idx_q)
        3'd0:    opcode_q       <= capt_q;
        3'd1:    operand_addr_q <= capt_q;
        3'd2:    byte2_q        <= capt_q;
        default: byte2_q        <= byte2_q;
      endcase
    end
  end

  // completion pulse and effects for one clock after the last state four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q   <= 1'b0;
      result_q <= '0;
    end else if (mstate_q == STATE_FOUR && last) begin
      done_q   <= 1'b1;
      result_q <= res;
    end else begin
      done_q   <= 1'b0;
      result_q <= '0;
    end
  end

endmodule

/* tb/branch_timing_monitor.sv */
// checker for machine cycle pacing and branch results
`timescale 1ns/100ps
module branch_timing_monitor
  import branch_timing_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // fetch port and operands
  input wire logic         fetch_en_q,
  input wire logic [15:0]  fetch_addr_q,
  input wire operands_t    ops,
  // decode state and results
  input wire mstate_t      mstate_q,
  input wire logic [7:0]   opcode_q,
  input wire logic [7:0]   operand_addr_q,
  input wire logic         done_q,
  input wire exec_result_t result_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_seq;
    $past(rst_n) |-> mstate_q == mstate_t'($past(mstate_q) + 2'd1);
  endproperty
  a_seq: assert property (p_seq) else $error("state order broken");
  property p_fetch_st1;
    fetch_en_q |-> mstate_q == STATE_ONE;
  endproperty
  a_fetch_st1: assert property (p_fetch_st1) else $error("fetch outside state one");
  property p_one_fetch;
    $past(rst_n) && fetch_en_q |=> !fetch_en_q [*3];
  endproperty
  a_one_fetch: assert property (p_one_fetch) else $error("two fetches in a cycle");
  property p_addr_hold;
    mstate_q != STATE_ONE |-> $stable(fetch_addr_q);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
  property p_done_st1;
    done_q |-> mstate_q == STATE_ONE && $past(mstate_q) == STATE_FOUR;
  endproperty
  a_done_st1: assert property (p_done_st1) else $error("done off cycle edge");
  property p_acc_nz;
    done_q && opcode_q == 8'h70 |-> result_q.taken == ($past(ops.acc) != 8'h00);
  endproperty
  a_acc_nz: assert property (p_acc_nz) else $error("acc jump wrong");
  property p_carry;
    done_q && opcode_q[7:5] == 3'b010 && opcode_q[3:0] == 4'h0
      |-> result_q.taken == ($past(ops.carry) ^ opcode_q[4]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry jump wrong");
  property p_bit_clr;
    done_q && opcode_q == 8'h10 |-> result_q.bit_clear == $past(ops.bit_val);
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");
  property p_dec_reg;
    done_q && opcode_q[7:3] == 5'h1b
      |-> result_q.dec_reg_we && result_q.dec_val == $past(ops.reg_val) - 8'd1;
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("decrement wrong");
  property p_cmp_imm;
    done_q && opcode_q == 8'hb4
      |-> result_q.carry_we && result_q.carry_val == ($past(ops.acc) < operand_addr_q);
  endproperty
  a_cmp_imm: assert property (p_cmp_imm) else $error("compare carry wrong");
endmodule

bind branch_decode_cycle_timing branch_timing_monitor u_branch_timing_monitor (
  .clk(clk), .rst_n(rst_n), .fetch_en_q(fetch_en_q), .fetch_addr_q(fetch_addr_q),
  .ops(ops), .mstate_q(mstate_q), .opcode_q(opcode_q), .operand_addr_q(operand_addr_q),
  .done_q(done_q), .result_q(result_q));

/* tb/prog_mem_model.sv */
// program memory model answering opcode fetches
`timescale 1ns/100ps
module prog_mem_model (
  // clock
  input  wire logic        clk,
  // fetch port
  input  wire logic        fetch_en_q,
  input  wire logic [15:0] fetch_addr_q,
  output logic [7:0]       fetch_data
);
  logic [7:0] mem [0:255];  // byte store, filled by the bench
  logic [1:0] age_q;        // clocks since the request
  // count clocks since the request, saturating
  always_ff @(posedge clk) begin
    if (fetch_en_q) begin
      age_q <= 2'd0;
    end else if (age_q != 2'd3) begin
      age_q <= age_q + 2'd1;
    end
  end
  // byte valid only in state three, inverse elsewhere
  assign fetch_data = (age_q == 2'd1) ? mem[fetch_addr_q[7:0]] : ~mem[fetch_addr_q[7:0]];
endmodule

/* tb/tb_branch_decode_cycle_timing.sv */
// self-checking bench for branch decode and cycle timing
`timescale 1ns/100ps
module tb_branch_decode_cycle_timing
  import branch_timing_pkg::*;
;
  logic         clk, rst_n, fetch_en_q, ext_move, done_q;
  logic [15:0]  fetch_addr_q, pc_q;
  logic [7:0]   fetch_data, opcode_q, operand_addr_q;
  logic [1:0]   other_bytes;
  operands_t    ops;
  mstate_t      mstate_q;
  exec_result_t result_q;
  int           fails, n_checks;

  branch_decode_cycle_timing u_branch_decode_cycle_timing (
    .clk(clk), .rst_n(rst_n), .fetch_en_q(fetch_en_q), .fetch_addr_q(fetch_addr_q),
    .fetch_data(fetch_data), .other_bytes(other_bytes), .ext_move(ext_move), .ops(ops),
    .mstate_q(mstate_q), .opcode_q(opcode_q), .operand_addr_q(operand_addr_q),
    .pc_q(pc_q), .done_q(done_q), .result_q(result_q));
  prog_mem_model u_prog_mem_model (
    .clk(clk), .fetch_en_q(fetch_en_q), .fetch_addr_q(fetch_addr_q),
    .fetch_data(fetch_data));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected {group, taken, carry, cycles}
  function automatic logic [5:0] expect_of(input logic [7:0] op, input operands_t o,
                                           input logic [7:0] d, input logic [1:0] ob,
                                           input logic xm);
    logic       g, t, cmp;
    logic [7:0] a, b;
    logic [2:0] cy;
    g = 1'b1;
    cmp = 1'b1;
    a = o.acc;
    b = d;
    t = 1'b0;
    if (op == 8'hb5) b = o.direct_val;
    else if (op[7:1] == 7'h5b) a = o.indirect_val;
    else if (op[7:3] == 5'h17) a = o.reg_val;
    else if (op != 8'hb4) cmp = 1'b0;
    if (cmp) t = a != b;
    else if (op == 8'h70) t = o.acc != 8'h00;
    else if (op[7:5] == 3'b010 && op[3:0] == 4'h0) t = o.carry ^ op[4];
    else if (op == 8'h20 || op == 8'h10) t = o.bit_val;
    else if (op == 8'h30) t = !o.bit_val;
    else if (op[7:3] == 5'h1b) t = o.reg_val != 8'h01;
    else if (op == 8'hd5) t = o.direct_val != 8'h01;
    else g = 1'b0;
    cy = (op == 8'h70 || op[7:5] == 3'b010 && op[3:0] == 4'h0 || op[7:3] == 5'h1b) ? 3'd3 : 3'd4;
    if (!g) cy = xm ? 3'd2 : (ob == 2'd0 ? 3'd1 : {1'b0, ob});
    return {g, t, a < b, cy};
  endfunction

  // one instruction from address zero; rnd low gives the corner set
  task automatic run(input logic [7:0] op, input logic rnd);
    logic [63:0] r;
    logic [5:0]  e;
    logic [7:0]  b1, b2, rel, dv;
    logic [15:0] len;
    logic        xm;
    operands_t   o;
    int          n;
    r = {$urandom, $urandom};
    b1 = rnd ? r[41:34] : 8'h01;
    b2 = rnd ? r[49:42] : 8'h80;
    o = rnd ? r[33:0] : {32'h01010101, 2'b00};
    xm = 1'b0;
    e = expect_of(op, o, b1, r[51:50], 1'b0);
    if (!e[5]) xm = r[52];
    e = expect_of(op, o, b1, r[51:50], xm);
    @(posedge clk);
    rst_n <= 1'b0;
    ops <= o;
    other_bytes <= r[51:50];
    ext_move <= xm;
    for (int i = 3; i < 256; i++) u_prog_mem_model.mem[i] = 8'($urandom);
    u_prog_mem_model.mem[0] = op;
    u_prog_mem_model.mem[1] = b1;
    u_prog_mem_model.mem[2] = b2;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done_q !== 1'b1 && n < 40);
    len = e[5] ? 16'(e[2:0] - 3'd1) : (xm ? 16'd1 : 16'(e[2:0]));
    rel = (len == 16'd2) ? b1 : b2;
    dv = ((op == 8'hd5) ? o.direct_val : o.reg_val) - 8'h01;
    check(16'(n), 16'(4 * e[2:0]));
    check(16'(opcode_q), 16'(op));
    check(16'(operand_addr_q), (len > 16'd1) ? 16'(b1) : 16'h0000);
    check(16'(result_q.taken), 16'(e[4]));
    if (op[7:4] == 4'hb && op > 8'hb3) check(16'(result_q.carry_val), 16'(e[3]));
    if (op == 8'h10) check(16'(result_q.bit_clear), 16'(o.bit_val));
    if (op[7:3] == 5'h1b || op == 8'hd5) begin
      check(16'({result_q.dec_direct_we, result_q.dec_val}), 16'({op == 8'hd5, dv}));
    end
    if (e[4]) len = len + {{8{rel[7]}}, rel};
    check(fetch_addr_q, len);
    check(pc_q, len + 16'd1);
    $display("test %h done", op);
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog
  initial begin
    #4000000;
    fails++;
    test_done();
  end
  // every opcode, once at the corner and once at random
  initial begin
    rst_n = 1'b0;
    other_bytes = 2'd0;
    ext_move = 1'b0;
    ops = '0;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'hde5c559f));
    for (int k = 0; k < 512; k++) begin
      run(k[8:1], k[0]);
    end
    test_done();
  end
endmodule
